// file: verilog/sttm_map.svh
// Register offsets, reset values and divider counts of the 10-bit timer
//----------------------------------------------------------------------
// Functional notes
// - Low-byte write loads only the shared buffer
// - High-byte write also copies buffer to low
// - High-byte read latches low byte into buffer
// - Core is 10-bit up-counter on selected clock
// - P compares counter top bits; A all
// - Period field times 128; zero means 1024
// - Counter clears on overflow or match, requests
// - On rise zeroes counter; off holds count
// - On rise restores output initial level
// - Pause bit freezes counter, clearing resumes
// - Three-bit select picks counter clock source
// - Two-bit mode field selects operating mode
// - Compare mode: keep, low, high, toggle
// - PWM: inactive, active, PWM, single pulse
// - Capture edge: rise, fall, both, none
// - Output control sets initial or active level
// - Same level as initial gives no change
// - Polarity bit inverts primary output except in timer mode
// - Counter read-only, compare A read/write
// - Secondary pin is inverse of primary
// - Clear select (compare, timer): P match, or A/overflow
// - Swap bit exchanges period and duty roles
//----------------------------------------------------------------------
`ifndef STTM_MAP_SVH
`define STTM_MAP_SVH

//----------------------------------------------------------------------
// Register byte offsets
//----------------------------------------------------------------------
`define STTM_OFF_CTRL0   8'h00
`define STTM_OFF_CTRL1   8'h04
`define STTM_OFF_CNT_LO  8'h08
`define STTM_OFF_CNT_HI  8'h0C
`define STTM_OFF_CMPA_LO 8'h10
`define STTM_OFF_CMPA_HI 8'h14

//----------------------------------------------------------------------
// Reset values and divider terminal counts
//----------------------------------------------------------------------
`define STTM_CTRL_RST    8'h00
`define STTM_BUF_RST     8'h00
`define STTM_DIV_SYS4    2'h3
`define STTM_DIV_H16     4'hF
`define STTM_DIV_H64     6'h3F
`define STTM_PER_SHIFT   7

`endif

// file: verilog/sttm_pkg.sv
// Types shared by the 10-bit timer design
package sttm_pkg;

   //-------------------------------------------------------------------
   // Enumerations
   //-------------------------------------------------------------------
   // Counter clock source
   typedef enum logic [2:0] {
      clk_sys_div4   = 3'b000,
      clk_sys        = 3'b001,
      clk_high_div16 = 3'b010,
      clk_high_div64 = 3'b011,
      clk_sub_a      = 3'b100,
      clk_sub_b      = 3'b101,
      clk_ext_rise   = 3'b110,
      clk_ext_fall   = 3'b111
   } sttm_clk_sel_t;

   // Operating mode
   typedef enum logic [1:0] {
      mode_compare = 2'b00,
      mode_capture = 2'b01,
      mode_pwm     = 2'b10,
      mode_timer   = 2'b11
   } sttm_mode_t;

   //-------------------------------------------------------------------
   // Register layouts, msb first
   //-------------------------------------------------------------------
   typedef struct packed {
      logic          pause_bit;
      sttm_clk_sel_t clock_select;
      logic          on_off_bit;
      logic [2:0]    period_field;
   } sttm_ctrl0_t;

   typedef struct packed {
      sttm_mode_t mode_field;
      logic [1:0] pin_function_field;
      logic       output_control_bit;
      logic       polarity_bit;
      logic       duty_period_swap;
      logic       clear_select_bit;
   } sttm_ctrl1_t;

   // Captured address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } sttm_bus_cmd_t;

   // Asynchronous inputs in sync order
   typedef struct packed {
      logic external_clock_pin;
      logic capture_input_pin;
      logic high_clock;
      logic sub_clock;
   } sttm_pins_t;

endpackage

// file: verilog/sttm_pin_sync.sv
// Two-stage synchroniser with edge pulses for asynchronous timer inputs
`timescale 1ns/10ps
module sttm_pin_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Raw inputs
   input  wire logic [W-1:0] pin_in,
   // Synchronised level and edges
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   //-------------------------------------------------------------------
   // Per-bit synchroniser
   //-------------------------------------------------------------------
   logic [W-1:0] meta;   // First stage, read only by second
   logic [W-1:0] prev;   // Previous synced level

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // Two flops, then a third for edge detection
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta[g]  <= 1'b0;
               level[g] <= 1'b0;
               prev[g]  <= 1'b0;
            end else if (ce) begin
               meta[g]  <= pin_in[g];
               level[g] <= meta[g];
               prev[g]  <= level[g];
            end
         end
         // Edge pulses from synced stages only
         assign rise[g] = level[g] & ~prev[g];
         assign fall[g] = ~level[g] & prev[g];
      end
   endgenerate

endmodule // sttm_pin_sync

// file: verilog/sttm_top.sv
// Standard 10-bit timer with AHB-Lite register access
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "sttm_map.svh"
module sttm_top #(
   parameter int CNT_W = 10
) (
   // Clock, reset and enable
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Clock sources and timer pins
   input  wire logic        high_clock,
   input  wire logic        sub_clock,
   input  wire logic        external_clock_pin,
   input  wire logic        capture_input_pin,
   output logic             primary_output_pin,
   output logic             inverted_output_pin,
   // Match requests
   output logic             match_a_req,
   output logic             match_p_req
);

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   sttm_pkg::sttm_ctrl0_t   ctrl0;        // Control register zero
   sttm_pkg::sttm_ctrl1_t   ctrl1;        // Control register one
   sttm_pkg::sttm_bus_cmd_t cmd;          // Pending data phase
   sttm_pkg::sttm_pins_t    pins_raw;     // Raw async inputs
   sttm_pkg::sttm_pins_t    pins_lvl;     // Synced levels
   sttm_pkg::sttm_pins_t    pins_rise;    // Synced rising edges
   sttm_pkg::sttm_pins_t    pins_fall;    // Synced falling edges
   logic [CNT_W-1:0]        count;        // Main up-counter
   logic [CNT_W-1:0]        compare_a;    // Comparator A value
   logic [CNT_W-1:0]        next_count1;  // Count plus one
   logic [CNT_W-1:0]        period_val;   // Period field scaled
   logic [CNT_W-1:0]        duty_val;     // PWM duty threshold
   logic [7:0]              hold_buf;     // Shared low-byte buffer
   logic [7:0]              rd_mux;       // Read data select
   logic [1:0]              sys_div;      // System clock divider
   logic [5:0]              high_div;     // High clock divider
   logic                    on_q;         // Delayed on/off bit
   logic                    on_rise;      // On/off low-to-high
   logic                    tick;         // Selected clock edge
   logic                    run;          // Counter advances
   logic                    hit_a;        // Comparator A match
   logic                    hit_p;        // Comparator P match
   logic                    ovf;          // Counter wraps
   logic                    clear_cnt;    // Counter clears
   logic                    cap_edge;     // Capture edge seen
   logic                    cap_event;    // Capture taken
   logic                    out_lvl;      // Compare-mode level
   logic                    pulse_on;     // Single pulse active
   logic                    pwm_lvl;      // Raw output level
   logic                    next_primary; // Primary pin next
   logic                    acc;          // Transfer accepted
   logic                    rd;           // Read address phase
   logic                    wr;           // Write data phase
   logic [7:0]              rd_addr;      // Read byte address

   //-------------------------------------------------------------------
   // Input synchronisers
   //-------------------------------------------------------------------
   assign pins_raw = '{external_clock_pin: external_clock_pin,
                       capture_input_pin:  capture_input_pin,
                       high_clock:         high_clock,
                       sub_clock:          sub_clock};

   sttm_pin_sync #(
      .W      ($bits(sttm_pkg::sttm_pins_t))
   ) u_sync (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .pin_in (pins_raw),
      .level  (pins_lvl),
      .rise   (pins_rise),
      .fall   (pins_fall)
   );

   //-------------------------------------------------------------------
   // Bus decode
   //-------------------------------------------------------------------
   // Accept NONSEQ or SEQ while the bus is ready
   assign acc     = ce & hsel & htrans[1] & hready;
   assign rd      = acc & ~hwrite;
   assign rd_addr = haddr[7:0];
   assign wr      = cmd.valid & cmd.write;

   // Address phase capture for write data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd <= '0;
      end else if (ce) begin
         cmd.valid <= acc;
         cmd.write <= hwrite;
         cmd.addr  <= haddr[7:0];
      end
   end

   // Read data select, low bytes come from the buffer
   always_comb begin
      case (rd_addr)
         `STTM_OFF_CTRL0:   rd_mux = ctrl0;
         `STTM_OFF_CTRL1:   rd_mux = ctrl1;
         `STTM_OFF_CNT_LO:  rd_mux = hold_buf;
         `STTM_OFF_CNT_HI:  rd_mux = 8'(count >> 8);
         `STTM_OFF_CMPA_LO: rd_mux = hold_buf;
         `STTM_OFF_CMPA_HI: rd_mux = 8'(compare_a >> 8);
         default:           rd_mux = 8'h00;
      endcase
   end

   // Zero-wait answer, always OKAY
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc) begin
            hrdata <= rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
         end
      end
   end

   //-------------------------------------------------------------------
   // Control registers
   //-------------------------------------------------------------------
   // Software writes, full byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl0 <= `STTM_CTRL_RST;
         ctrl1 <= `STTM_CTRL_RST;
      end else if (ce && wr) begin
         if (cmd.addr == `STTM_OFF_CTRL0) begin
            ctrl0 <= hwdata[7:0];
         end
         if (cmd.addr == `STTM_OFF_CTRL1) begin
            ctrl1 <= hwdata[7:0];
         end
      end
   end

   //-------------------------------------------------------------------
   // Low-byte holding buffer
   //-------------------------------------------------------------------
   // A read is later in program order than a pending write, so it wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_buf <= `STTM_BUF_RST;
      end else if (ce) begin
         if (rd && rd_addr == `STTM_OFF_CNT_HI) begin
            hold_buf <= count[7:0];
         end else if (rd && rd_addr == `STTM_OFF_CMPA_HI) begin
            hold_buf <= compare_a[7:0];
         end else if (wr && cmd.addr == `STTM_OFF_CMPA_LO) begin
            hold_buf <= hwdata[7:0];
         end
      end
   end

   //-------------------------------------------------------------------
   // Comparator A value
   //-------------------------------------------------------------------
   // Capture beats a software write in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         compare_a <= '0;
      end else if (ce) begin
         if (cap_event) begin
            compare_a <= count;
         end else if (wr && cmd.addr == `STTM_OFF_CMPA_HI) begin
            compare_a <= {hwdata[CNT_W-9:0], hold_buf};
         end
      end
   end

   //-------------------------------------------------------------------
   // Clock prescalers
   //-------------------------------------------------------------------
   // System divider free runs, high divider counts synced edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_div  <= 2'h0;
         high_div <= 6'h00;
      end else if (ce) begin
         sys_div <= sys_div + 2'h1;
         if (pins_rise.high_clock) begin
            high_div <= high_div + 6'h01;
         end
      end
   end

   // Clock source select
   always_comb begin
      unique case (ctrl0.clock_select)
         sttm_pkg::clk_sys_div4:   tick = (sys_div == `STTM_DIV_SYS4);
         sttm_pkg::clk_sys:        tick = 1'b1;
         sttm_pkg::clk_high_div16: tick = pins_rise.high_clock &&
                                          high_div[3:0] == `STTM_DIV_H16;
         sttm_pkg::clk_high_div64: tick = pins_rise.high_clock &&
                                          high_div == `STTM_DIV_H64;
         sttm_pkg::clk_sub_a:      tick = pins_rise.sub_clock;
         sttm_pkg::clk_sub_b:      tick = pins_rise.sub_clock;
         sttm_pkg::clk_ext_rise:   tick = pins_rise.external_clock_pin;
         sttm_pkg::clk_ext_fall:   tick = pins_fall.external_clock_pin;
      endcase
   end

   //-------------------------------------------------------------------
   // Comparators
   //-------------------------------------------------------------------
   assign on_rise     = ctrl0.on_off_bit & ~on_q;
   // Advance only while on, unpaused, on a selected edge
   assign run         = ctrl0.on_off_bit & ~ctrl0.pause_bit & tick;
   assign next_count1 = count + CNT_W'(1);
   // Period field in the top three bits; zero wraps at the maximum
   assign period_val  = CNT_W'({ctrl0.period_field, 7'h00});
   assign hit_p       = run & (next_count1[CNT_W-1 -: 3] ==
                               ctrl0.period_field) &
                        (next_count1[CNT_W-4:0] == '0);
   assign hit_a       = run & (next_count1 == compare_a) &
                        (compare_a != '0);
   assign ovf         = run & (&count);

   // Clear source by mode and clear select
   always_comb begin
      unique case (ctrl1.mode_field)
         sttm_pkg::mode_pwm:     clear_cnt = ctrl1.duty_period_swap ?
                                             hit_a : hit_p;
         sttm_pkg::mode_capture: clear_cnt = hit_p;
         sttm_pkg::mode_compare,
         sttm_pkg::mode_timer:   clear_cnt = ctrl1.clear_select_bit ?
                                             (hit_a | ovf) : hit_p;
      endcase
   end

   //-------------------------------------------------------------------
   // Counter
   //-------------------------------------------------------------------
   // Software cannot load it; the on edge or a clear source zeroes it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
         on_q  <= 1'b0;
      end else if (ce) begin
         on_q <= ctrl0.on_off_bit;
         if (on_rise) begin
            count <= '0;
         end else if (run) begin
            count <= clear_cnt ? '0 : next_count1;
         end
      end
   end

   // Match requests, P suppressed when A clears in compare and timer modes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         match_a_req <= 1'b0;
         match_p_req <= 1'b0;
      end else if (ce) begin
         match_a_req <= hit_a;
         match_p_req <= hit_p & ~(ctrl1.clear_select_bit &
                        ctrl1.mode_field[0] == ctrl1.mode_field[1]);
      end
   end

   //-------------------------------------------------------------------
   // Capture input
   //-------------------------------------------------------------------
   always_comb begin
      unique case (ctrl1.pin_function_field)
         2'b00: cap_edge = pins_rise.capture_input_pin;
         2'b01: cap_edge = pins_fall.capture_input_pin;
         2'b10: cap_edge = pins_rise.capture_input_pin |
                           pins_fall.capture_input_pin;
         2'b11: cap_edge = 1'b0;
      endcase
   end
   assign cap_event = cap_edge & ctrl0.on_off_bit &
                      (ctrl1.mode_field == sttm_pkg::mode_capture);

   //-------------------------------------------------------------------
   // Output state
   //-------------------------------------------------------------------
   // Compare level and single-pulse state; on edge restores initial
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_lvl  <= 1'b0;
         pulse_on <= 1'b0;
      end else if (ce) begin
         if (on_rise) begin
            out_lvl  <= ctrl1.output_control_bit;
            pulse_on <= 1'b0;
         end else if (ctrl1.mode_field == sttm_pkg::mode_compare && hit_a) begin
            unique case (ctrl1.pin_function_field)
               2'b00: out_lvl <= out_lvl;
               2'b01: out_lvl <= 1'b0;
               2'b10: out_lvl <= 1'b1;
               2'b11: out_lvl <= ~out_lvl;
            endcase
         end else if (ctrl1.mode_field == sttm_pkg::mode_pwm) begin
            // Pulse starts on an external trigger, ends on A match
            if (hit_a) begin
               pulse_on <= 1'b0;
            end else if (pins_rise.external_clock_pin && ctrl0.on_off_bit) begin
               pulse_on <= 1'b1;
            end
         end
      end
   end

   // Duty threshold follows the swap bit
   assign duty_val = ctrl1.duty_period_swap ? period_val : compare_a;

   // Raw level per mode and pin function
   always_comb begin
      unique case (ctrl1.mode_field)
         sttm_pkg::mode_pwm: begin
            unique case (ctrl1.pin_function_field)
               2'b00: pwm_lvl = ~ctrl1.output_control_bit;
               2'b01: pwm_lvl = ctrl1.output_control_bit;
               2'b10: pwm_lvl = (count < duty_val) ?
                                ctrl1.output_control_bit :
                                ~ctrl1.output_control_bit;
               2'b11: pwm_lvl = pulse_on ?
                                ctrl1.output_control_bit :
                                ~ctrl1.output_control_bit;
            endcase
         end
         sttm_pkg::mode_compare,
         sttm_pkg::mode_capture,
         sttm_pkg::mode_timer: pwm_lvl = out_lvl;
      endcase
   end

   // Polarity ignored in timer mode
   assign next_primary = (ctrl1.mode_field == sttm_pkg::mode_timer) ?
                         pwm_lvl : pwm_lvl ^ ctrl1.polarity_bit;

   // Registered pin pair
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         primary_output_pin  <= 1'b0;
         inverted_output_pin <= 1'b1;
      end else if (ce) begin
         primary_output_pin  <= next_primary;
         inverted_output_pin <= ~next_primary;
      end
   end

endmodule // sttm_top

// file: dv/sttm_pin_model.sv
// Far-side pin source for the external and slow clock inputs
`timescale 1ns/10ps
module sttm_pin_model (
   // Clock and enable
   input  wire logic clk,
   input  wire logic en,
   // Driven pins
   output logic      ext_pin,
   output logic      slow_clk
);
   logic [1:0] div;  // Half period counter
   // Pin toggles every four clocks while enabled, idles low otherwise
   always_ff @(posedge clk) begin
      div <= en ? div + 2'h1 : 2'h0;
      if (!en) ext_pin <= 1'b0;
      else if (div == 2'h3) ext_pin <= !ext_pin;
   end
   assign slow_clk = ext_pin;  // Same waveform for high and sub clock
endmodule // sttm_pin_model

// file: dv/sttm_top_chk.sv
// Port assertions for the 10-bit timer top
`timescale 1ns/10ps
module sttm_top_chk #(
   parameter int CNT_W = 10
) (
   // Clock, bus and pins
   input logic clk, rst, ce, hsel, hwrite, hready, hreadyout, hresp,
   input logic [31:0] haddr, hwdata, hrdata,
   input logic [1:0] htrans,
   input logic [2:0] hsize,
   input logic high_clock, sub_clock, external_clock_pin, capture_input_pin,
   input logic primary_output_pin, inverted_output_pin, match_a_req, match_p_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Accepted address phase, and reads of a high byte
   sequence s_take; hsel && htrans[1] && hready && ce; endsequence
   sequence s_rd_hi; s_take ##0 (!hwrite && haddr[7:0] inside {8'h0C, 8'h14}); endsequence
   AST_INV_PIN: assert property (inverted_output_pin == !primary_output_pin)
      else $error("inverted pin is not the inverse of primary");
   AST_RST_OUT: assert property ($fell(rst) |-> !primary_output_pin && !match_a_req)
      else $error("outputs not idle after reset");
   AST_RD_HOLD: assert property (!(hsel && htrans[1] && hready && ce) |=> $stable(hrdata))
      else $error("read data moved without a transfer");
   AST_HI_NARROW: assert property (s_rd_hi |=> hrdata[31:2] == 30'h0)
      else $error("high byte read shows bits above 9");
   AST_BYTE_WIDE: assert property (hrdata[31:8] == 24'h0)
      else $error("read data wider than a byte");
   AST_OKAY: assert property (!hresp)
      else $error("bus response not okay");
   AST_NO_WAIT: assert property (hreadyout)
      else $error("slave inserted a wait state");
   AST_P_SINGLE: assert property (match_p_req |=> !match_p_req [*8])
      else $error("period match repeated too soon");
endmodule // sttm_top_chk
bind sttm_top sttm_top_chk #(.CNT_W(CNT_W)) u_chk (.*);

// file: dv/standard_10bit_timer_module_bench.sv
// Self-checking bench for the 10-bit timer
`timescale 1ns/10ps
module standard_10bit_timer_module_bench;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, pen = 0, cap = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c0, c1;
   logic hrdy, hresp, pout, nout, ma, mp, ext, slow;
   int failures = 0, comparisons = 0, cyc = 0, n, edges;
   // Rows: address in upper byte, expected read in lower byte
   logic [15:0] rows [7] = '{16'h0000, 16'h0400, 16'h1400, 16'h1000, 16'h1800, 16'h0C00, 16'h0800};
   always #2 clk = !clk;
   always @(posedge ext) edges++;
   sttm_pin_model PM (.clk(clk), .en(pen), .ext_pin(ext), .slow_clk(slow));
   sttm_top DUT (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
      .hrdata(hrdata), .hresp(hresp), .high_clock(slow), .sub_clock(slow),
      .external_clock_pin(ext), .capture_input_pin(cap), .primary_output_pin(pout),
      .inverted_output_pin(nout), .match_a_req(ma), .match_p_req(mp));
   task automatic results;
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single word transfer, waiting on ready in both phases
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0; hwdata <= w ? d : 32'h0;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk("register read", e, rd);
   endtask
   // Register pair read from its low byte offset, high byte first
   task automatic getc(input logic [7:0] a, output logic [31:0] c);
      xfer(1'b0, a + 8'h04, 32'h0);
      c = rd;
      xfer(1'b0, a, 32'h0);
      c = {22'h0, c[1:0], rd[7:0]};
   endtask
   task automatic run(input int k);
      pen <= 1'b1;
      repeat (k) @(posedge clk);
      pen <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         results;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) rdc(rows[i][15:8], {24'h0, rows[i][7:0]});
      xfer(1'b1, 8'h10, 32'h0000_00A5);
      rdc(8'h14, 32'h0);
      rdc(8'h10, 32'h0);
      xfer(1'b1, 8'h10, 32'h0000_00A5);
      xfer(1'b1, 8'h14, 32'h0000_0002);
      rdc(8'h14, 32'h2);
      rdc(8'h10, 32'hA5);
      xfer(1'b1, 8'h0C, 32'h0000_0003);
      rdc(8'h0C, 32'h0);
      // System clock, on, period 128 clocks
      xfer(1'b1, 8'h00, 32'h0000_0019);
      while (mp !== 1'b1) @(posedge clk);
      @(posedge clk);
      n = 1;
      while (mp !== 1'b1) begin
         n++;
         @(posedge clk);
      end
      chk("period match spacing", 32'd128, n);
      // External rising edge clock, zeroed by on rise
      xfer(1'b1, 8'h00, 32'h0000_0060);
      xfer(1'b1, 8'h00, 32'h0000_0068);
      edges = 0;
      run(100);
      getc(8'h08, c0);
      chk("edge count", edges, c0);
      xfer(1'b1, 8'h00, 32'h0000_00E8);
      run(60);
      getc(8'h08, c1);
      chk("paused count", c0, c1);
      xfer(1'b1, 8'h00, 32'h0000_0060);
      run(60);
      getc(8'h08, c1);
      chk("off count", c0, c1);
      // Compare A of ten, toggle, initial high
      xfer(1'b1, 8'h10, 32'h0000_000A);
      xfer(1'b1, 8'h14, 32'h0);
      xfer(1'b1, 8'h04, 32'h0000_0039);
      xfer(1'b1, 8'h00, 32'h0000_0018);
      // On edge, then level, then registered pin
      repeat (3) @(posedge clk);
      chk("initial level", 32'h1, pout);
      while (ma !== 1'b1) @(posedge clk);
      repeat (3) @(posedge clk);
      chk("toggled level", 32'h0, pout);
      chk("inverted pin", 32'h1, nout);
      // Polarity inverts the initial level
      xfer(1'b1, 8'h00, 32'h0000_0010);
      xfer(1'b1, 8'h04, 32'h0000_003D);
      xfer(1'b1, 8'h00, 32'h0000_0018);
      repeat (3) @(posedge clk);
      chk("inverted level", 32'h0, pout);
      // Capture of a paused count on a rising input edge
      xfer(1'b1, 8'h00, 32'h0000_0010);
      xfer(1'b1, 8'h04, 32'h0000_0040);
      xfer(1'b1, 8'h00, 32'h0000_0018);
      repeat (50) @(posedge clk);
      xfer(1'b1, 8'h00, 32'h0000_0098);
      cap <= 1'b1;
      repeat (8) @(posedge clk);
      getc(8'h08, c0);
      getc(8'h10, c1);
      chk("captured count", c0, c1);
      // Mid-run reset returns registers and pins to idle
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset pin", 32'h0, pout);
      rdc(8'h04, 32'h0);
      results;
   end
endmodule // standard_10bit_timer_module_bench
